// file: design/imt_interval_match_timer.sv
/*
  imt_interval_match_timer: two-channel compare match interval timer with a
  register port, a status/mask interrupt pair and one match_irq per channel.
  Assumes a master that holds strobes one cycle, never both at once.
*/
// Overview of operation
// - running channel counts one per chosen tick
// - counter equal limit clears counter, sets flag
// - counting resumes from zero after a match
// - four ticks: clock divided 8,32,128,512
// - per-channel irq when flag and enable set
// - match acts on the following counter tick
// - flag clears only by read-1 then write-0
// - match clear beats a counter write
// - word write beats a count-up
// - byte write skips count, other byte kept
// - equal stopped writes set flag, clear counter
// - select codes 00..11 map to /8../512
// - one run bit per channel, 1 counts
// - reset gives counter zero, limit all ones
// - reset clears run and control registers
`timescale 1ns/1ns

// one divided tick: a single-cycle enable when the masked prescaler bits are all ones
module imt_tick_gen #(
  parameter logic [8:0] Mask = 9'h007
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [8:0] count,
  output logic tick
);
  import imt_pkg::*;
  // registered so every channel sees the same clean pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      tick <= 1'b0;
    end else begin
      tick <= (count & Mask) == Mask;
    end
  end
endmodule // imt_tick_gen

module imt_channel (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] tickIn,
  input wire logic run,
  input wire imt_pkg::imt_bus_req_type req,
  input wire logic [3:0] offCtrl,
  input wire logic [3:0] offCount,
  input wire logic [3:0] offLimit,
  output logic [15:0] ctrlRd,
  output logic [15:0] countRd,
  output logic [15:0] limitRd,
  output logic matchEvent,
  output logic irq
);
  import imt_pkg::*;
  logic [15:0] count_q;
  logic [15:0] limit_q;
  logic flag_q;
  logic irqEn_q;
  logic [1:0] clkSel_q;
  logic flagSeen_q;
  logic equal_q;
  logic tick;
  logic wrCtrl;
  logic wrCount;
  logic wrLimit;
  logic matchClr;
  logic stopEqual;
  logic [15:0] merged;

  assign wrCtrl = req.wr && req.addr == offCtrl;
  assign wrCount = req.wr && req.addr == offCount;
  assign wrLimit = req.wr && req.addr == offLimit;
  assign tick = run && tickIn[clkSel_q];
  // equality is remembered and acted on at the next tick
  assign matchClr = tick && equal_q;
  // stopped counter written equal to limit, or limit written equal to it
  assign stopEqual = !run && ((wrCount && merged == limit_q) ||
                              (wrLimit && req.wdata == count_q));
  assign merged = {req.byteEn[1] ? req.wdata[15:8] : count_q[15:8],
                   req.byteEn[0] ? req.wdata[7:0] : count_q[7:0]};

  always_ff @(posedge mclk) begin
    if (rst) begin
      equal_q <= 1'b0;
    end else begin
      equal_q <= (count_q == limit_q);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_q <= CounterReset;
    end else if (matchClr || stopEqual) begin
      count_q <= CounterReset;
    end else if (wrCount) begin
      count_q <= merged;
    end else if (tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      limit_q <= LimitReset;
    end else if (wrLimit) begin
      limit_q <= req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqEn_q <= CtrlReset[IrqEnBit];
      clkSel_q <= CtrlReset[ClkSelHiBit:ClkSelLoBit];
    end else if (wrCtrl && req.byteEn[0]) begin
      irqEn_q <= req.wdata[IrqEnBit];
      clkSel_q <= req.wdata[ClkSelHiBit:ClkSelLoBit];
    end
  end

  // set beats clear; write of 1 leaves the flag alone
  always_ff @(posedge mclk) begin
    if (rst) begin
      flag_q <= CtrlReset[FlagBit];
      flagSeen_q <= 1'b0;
    end else begin
      if (matchClr || stopEqual) begin
        flag_q <= 1'b1;
      end else if (wrCtrl && req.byteEn[0] && !req.wdata[FlagBit] && flagSeen_q) begin
        flag_q <= 1'b0;
      end
      if (req.rd && req.addr == offCtrl) begin
        flagSeen_q <= flag_q;
      end else if (wrCtrl) begin
        flagSeen_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
      matchEvent <= 1'b0;
    end else begin
      irq <= (flag_q || matchClr || stopEqual) && irqEn_q;
      matchEvent <= matchClr || stopEqual;
    end
  end

  assign ctrlRd = {8'h00, flag_q, irqEn_q, 4'h0, clkSel_q};
  assign countRd = count_q;
  assign limitRd = limit_q;
endmodule // imt_channel

module imt_interval_match_timer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [imt_pkg::AddrW-1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [1:0] regByteEn,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  output logic [1:0] matchIrq,
  output logic timerIrq
);
  import imt_pkg::*;
  imt_bus_req_type req;
  logic [8:0] prescale_q;
  logic [3:0] tick_q;
  logic [1:0] run_q;
  logic [1:0] irqStatus_q;
  logic [1:0] irqMask_q;
  logic [1:0] matchEvent;
  logic [15:0] ctrlRd [2];
  logic [15:0] countRd [2];
  logic [15:0] limitRd [2];
  logic [15:0] rdMux;
  logic [3:0] offCtrl [2];
  logic [3:0] offCount [2];
  logic [3:0] offLimit [2];

  assign req = '{addr: regAddr, wdata: regWdata, byteEn: regByteEn, wr: regWr, rd: regRd};
  assign offCtrl = '{OffCtrlStatus0, OffCtrlStatus1};
  assign offCount = '{OffCounter0, OffCounter1};
  assign offLimit = '{OffLimit0, OffLimit1};

  // one shared free-running prescaler keeps all logic on mclk
  always_ff @(posedge mclk) begin
    if (rst) begin
      prescale_q <= 9'h000;
    end else begin
      prescale_q <= prescale_q + 9'h001;
    end
  end

  imt_tick_gen #(.Mask(Div8M1)) uTick8 (
    .mclk(mclk),
    .rst(rst),
    .count(prescale_q),
    .tick(tick_q[SelDiv8])
  );

  imt_tick_gen #(.Mask(Div32M1)) uTick32 (
    .mclk(mclk),
    .rst(rst),
    .count(prescale_q),
    .tick(tick_q[SelDiv32])
  );

  imt_tick_gen #(.Mask(Div128M1)) uTick128 (
    .mclk(mclk),
    .rst(rst),
    .count(prescale_q),
    .tick(tick_q[SelDiv128])
  );

  imt_tick_gen #(.Mask(Div512M1)) uTick512 (
    .mclk(mclk),
    .rst(rst),
    .count(prescale_q),
    .tick(tick_q[SelDiv512])
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      run_q <= RunReset[1:0];
    end else if (regWr && regAddr == OffRunSelect && regByteEn[0]) begin
      run_q <= regWdata[1:0];
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : gChan
      imt_channel uChan (
        .mclk(mclk),
        .rst(rst),
        .tickIn(tick_q),
        .run(run_q[ch]),
        .req(req),
        .offCtrl(offCtrl[ch]),
        .offCount(offCount[ch]),
        .offLimit(offLimit[ch]),
        .ctrlRd(ctrlRd[ch]),
        .countRd(countRd[ch]),
        .limitRd(limitRd[ch]),
        .matchEvent(matchEvent[ch]),
        .irq(matchIrq[ch])
      );
    end
  endgenerate

  // sticky status: a read clears it, but a same-cycle event still sets
  always_ff @(posedge mclk) begin
    if (rst) begin
      irqStatus_q <= 2'b00;
    end else if (regRd && regAddr == OffIrqStatus) begin
      irqStatus_q <= matchEvent;
    end else begin
      irqStatus_q <= irqStatus_q | matchEvent;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irqMask_q <= 2'b00;
    end else if (regWr && regAddr == OffIrqMask && regByteEn[0]) begin
      irqMask_q <= regWdata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      timerIrq <= 1'b0;
    end else begin
      timerIrq <= |((irqStatus_q | matchEvent) & irqMask_q);
    end
  end

  always_comb begin
    case (regAddr)
      OffRunSelect: rdMux = {14'h0000, run_q};
      OffCtrlStatus0: rdMux = ctrlRd[0];
      OffCounter0: rdMux = countRd[0];
      OffLimit0: rdMux = limitRd[0];
      OffCtrlStatus1: rdMux = ctrlRd[1];
      OffCounter1: rdMux = countRd[1];
      OffLimit1: rdMux = limitRd[1];
      OffIrqStatus: rdMux = {14'h0000, irqStatus_q};
      OffIrqMask: rdMux = {14'h0000, irqMask_q};
      default: rdMux = 16'h0000;
    endcase
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (rst) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      regRdata <= rdMux;
    end else begin
      regRdata <= 16'h0000;
    end
  end
endmodule // imt_interval_match_timer

// file: design/imt_pkg.sv
/*
  imt_pkg: constants and carrier types for the two-channel interval match timer.
  Assumes one 100 MHz clock (mclk) and a plain register port of 16-bit words.
*/
package imt_pkg;
  localparam int ClkMhz = 100;
  localparam int AddrW = 4;
  // register offsets (word index)
  localparam logic [3:0] OffRunSelect = 4'h0;
  localparam logic [3:0] OffCtrlStatus0 = 4'h1;
  localparam logic [3:0] OffCounter0 = 4'h2;
  localparam logic [3:0] OffLimit0 = 4'h3;
  localparam logic [3:0] OffCtrlStatus1 = 4'h4;
  localparam logic [3:0] OffCounter1 = 4'h5;
  localparam logic [3:0] OffLimit1 = 4'h6;
  localparam logic [3:0] OffIrqStatus = 4'h7;
  localparam logic [3:0] OffIrqMask = 4'h8;
  // control/status field positions
  localparam int FlagBit = 7;
  localparam int IrqEnBit = 6;
  localparam int ClkSelHiBit = 1;
  localparam int ClkSelLoBit = 0;
  // reset values
  localparam logic [15:0] CounterReset = 16'h0000;
  localparam logic [15:0] LimitReset = 16'hffff;
  localparam logic [15:0] CtrlReset = 16'h0000;
  localparam logic [15:0] RunReset = 16'h0000;
  // prescaler divide ratios, minus one, for select codes 00..11
  localparam logic [8:0] Div8M1 = 9'h007;
  localparam logic [8:0] Div32M1 = 9'h01f;
  localparam logic [8:0] Div128M1 = 9'h07f;
  localparam logic [8:0] Div512M1 = 9'h1ff;

  typedef enum logic [1:0] {
    SelDiv8,
    SelDiv32,
    SelDiv128,
    SelDiv512
  } imt_clksel_type;

  typedef struct packed {
    logic [AddrW-1:0] addr;
    logic [15:0] wdata;
    logic [1:0] byteEn;
    logic wr;
    logic rd;
  } imt_bus_req_type;
endpackage

// file: testbench/imt_interval_match_timer_monitor.sv
/* imt_interval_match_timer_monitor: port assertions for the timer.
   assumes a bind from tb_top and imt_pkg compiled first. */
`timescale 1ns/1ns
module imt_interval_match_timer_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [imt_pkg::AddrW-1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic [1:0] regByteEn,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regRdata,
  input wire logic [1:0] matchIrq,
  input wire logic timerIrq
);
  import imt_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_idle; !regRd |=> regRdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_unmap; regRd && regAddr > OffIrqMask |=> regRdata == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_irq0;
    regRd && regAddr == OffCtrlStatus0 |=> (regRdata[7] & regRdata[6]) == $past(matchIrq[0]);
  endproperty
  a_irq0: assert property (p_irq0) else $error("ch0 irq vs flag");
  property p_irq1;
    regRd && regAddr == OffCtrlStatus1 |=> (regRdata[7] & regRdata[6]) == $past(matchIrq[1]);
  endproperty
  a_irq1: assert property (p_irq1) else $error("ch1 irq vs flag");
  property p_rsvd; regRd && regAddr == OffCtrlStatus0 |=> regRdata[5:2] == 4'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("ctrl spare bits set");
  property p_run; regRd && regAddr == OffRunSelect |=> regRdata[15:2] == 14'h0; endproperty
  a_run: assert property (p_run) else $error("run spare bits set");
  property p_mask; regRd && regAddr == OffIrqMask ##1 regRdata == 16'h0000 |-> !timerIrq;
  endproperty
  a_mask: assert property (p_mask) else $error("irq with zero mask");
  property p_rst; $fell(rst) |-> matchIrq == 2'b00 && !timerIrq; endproperty
  a_rst: assert property (p_rst) else $error("irq after reset");
  c_flag: cover property (regRd && regAddr == OffCtrlStatus0 ##1 regRdata[7]);
  c_irq: cover property ($rose(matchIrq[0]));
  c_top: cover property (matchIrq[0] && timerIrq);
endmodule // imt_interval_match_timer_monitor

// file: testbench/imt_irq_sink.sv
/* imt_irq_sink: interrupt controller side, counts request rises per channel.
   assumes level requests on the same clock. */
`timescale 1ns/1ns
module imt_irq_sink (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] irqIn,
  output logic [15:0] riseCnt0,
  output logic [15:0] riseCnt1
);
  logic [1:0] prev_q;
  // separate counts: channels must not leak into each other
  always_ff @(posedge mclk) begin
    prev_q <= rst ? 2'b00 : irqIn;
    riseCnt0 <= rst ? 16'h0000 : riseCnt0 + 16'(irqIn[0] & !prev_q[0]);
    riseCnt1 <= rst ? 16'h0000 : riseCnt1 + 16'(irqIn[1] & !prev_q[1]);
  end
endmodule // imt_irq_sink

// file: testbench/tb_top.sv
/* tb_top: register-level tests of the interval match timer.
   assumes imt_pkg, design, monitor and irq sink compiled before. */
`timescale 1ns/1ns
module tb_top;
  import imt_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [AddrW-1:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic [1:0] regByteEn = 2'b11;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata, v, rise0, rise1;
  logic [1:0] matchIrq;
  logic timerIrq;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  int t0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  imt_interval_match_timer i_imt_interval_match_timer (.mclk, .rst, .regAddr, .regWdata,
    .regByteEn, .regWr, .regRd, .regRdata, .matchIrq, .timerIrq);
  imt_irq_sink i_imt_irq_sink (.mclk, .rst, .irqIn(matchIrq), .riseCnt0(rise0),
    .riseCnt1(rise1));
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be = 2'b11);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    regByteEn <= be;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    rd(a);
    cmp(v, exp);
  endtask
  // bounded poll; sampling 1 ns past the edge keeps both rises aligned
  task automatic wait_irq;
    repeat (2) @(posedge mclk);
    #1;
    for (int i = 0; i < 5000 && matchIrq[0] !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rdc(OffRunSelect, RunReset);
    rdc(OffCtrlStatus0, CtrlReset);
    rdc(OffCtrlStatus1, CtrlReset);
    rdc(OffCounter0, CounterReset);
    rdc(OffLimit1, LimitReset);
    rdc(OffIrqMask, 16'h0000);
    rdc(4'hf, 16'h0000);
    $display("test reset done");
    wr(OffIrqMask, 16'h0001);
    wr(OffCounter0, 16'h1234);
    wr(OffCounter0, 16'hab00, 2'b10);
    rdc(OffCounter0, 16'hab34);
    wr(OffLimit0, 16'hab34);
    rdc(OffCounter0, 16'h0000);
    rdc(OffCtrlStatus0, 16'h0080);
    cmp({15'h0, timerIrq}, 16'h0001);
    rdc(OffIrqStatus, 16'h0001);
    rdc(OffIrqStatus, 16'h0000);
    wr(OffCtrlStatus0, 16'h00c0);
    wr(OffCtrlStatus0, 16'h0040);
    rdc(OffCtrlStatus0, 16'h00c0);
    cmp({14'h0, matchIrq}, 16'h0001);
    wr(OffCtrlStatus0, 16'h0040);
    rdc(OffCtrlStatus0, 16'h0040);
    $display("test flag done");
    wr(OffLimit0, 16'h0003);
    for (int s = 0; s < 4; s++) begin
      wr(OffCtrlStatus0, 16'h0040 | 16'(s));
      wr(OffRunSelect, 16'h0001);
      wait_irq();
      t0 = cyc;
      rd(OffCtrlStatus0);
      wr(OffCtrlStatus0, 16'h0040 | 16'(s));
      wait_irq();
      cmp(16'(cyc - t0), 16'(32 << (2 * s)));
      wr(OffRunSelect, 16'h0000);
      rd(OffCtrlStatus0);
    end
    cmp(rise0, 16'h0009);
    cmp(rise1, 16'h0000);
    rdc(OffIrqStatus, 16'h0001);
    $display("test period done");
    give_verdict();
  end
endmodule // tb_top
bind imt_interval_match_timer imt_interval_match_timer_monitor
  i_imt_interval_match_timer_monitor (.mclk, .rst, .regAddr, .regWdata, .regByteEn, .regWr,
  .regRd, .regRdata, .matchIrq, .timerIrq);
